// File: verilog/pss_pkg.sv
// shared constants and carrier types for the page select supervisor
`default_nettype none
package pss_pkg;
  localparam int          CLK_HZ        = 25_000_000;
  localparam int          REFRESH_MS    = 5;
  localparam int          WDT_MS        = 210;
  localparam int          REFRESH_CYC   = CLK_HZ / 1000 * REFRESH_MS;
  localparam int          WDT_CYC       = CLK_HZ / 1000 * WDT_MS;
  localparam int          CNT_W         = 23;
  localparam logic [7:0]  REG_PAGE_OFS  = 8'h00;
  localparam logic [7:0]  PAGE_RESET    = 8'h00;
  localparam logic [7:0]  PAGE_SUP_LAST = 8'h0f;
  localparam logic [7:0]  PAGE_TEMP_INT = 8'h11;
  localparam logic [7:0]  PAGE_TEMP_END = 8'h15;
  localparam logic [7:0]  PAGE_ALL      = 8'hff;
  localparam logic [7:0]  CMD_PAGE      = 8'h00;
  localparam logic [7:0]  CMD_CLEAR     = 8'h03;
  localparam logic [7:0]  DAC_BASE      = 8'h20;
  localparam logic [7:0]  TEMP_BASE     = 8'h90;
  localparam int          VST_WDOG      = 6;
  localparam int          VST_FAULT_IN  = 0;

  typedef enum logic [3:0] {
    K_SUP  = 4'b0001,
    K_TEMP = 4'b0010,
    K_ALL  = 4'b0100,
    K_RSVD = 4'b1000
  } page_kind_t;

  typedef enum logic [3:0] {
    PH_LOAD  = 4'b0001,
    PH_CHECK = 4'b0010,
    PH_NULL  = 4'b0100,
    PH_RUN   = 4'b1000
  } phase_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic       supply_only;
    logic       temp_only;
    logic [7:0] code;
    logic [7:0] data;
  } cmd_t;

  typedef struct packed {
    logic        alert_en;
    logic        fault_ignore;
    logic [15:0] global_mask;
  } cfg_t;

  typedef struct packed {
    logic [15:0] supply_sel;
    logic [4:0]  temp_sel;
    logic        all_pages;
    logic [7:0]  margin_addr;
    logic [1:0]  margin_out;
    logic [7:0]  remote_addr;
  } route_t;

  typedef struct packed {
    logic vendor_summary;
    logic comm_fault;
    logic watchdog;
    logic fault_level;
  } status_t;
endpackage
`default_nettype wire

// File: verilog/page_select_supervisor.sv
// page select, watchdog, integrity check, shared fault line and monitor disable
`default_nettype none
module page_select_supervisor
  import pss_pkg::*;
#(
  parameter int REFRESH_CYCLES = pss_pkg::REFRESH_CYC,
  parameter int WDT_CYCLES     = pss_pkg::WDT_CYC
) (
  input  wire logic            CLK,
  input  wire logic            RST_B,
  input  wire pss_pkg::cmd_t   CMD,
  input  wire logic            DATA_FAULT,
  input  wire pss_pkg::cfg_t   CFG,
  input  wire logic            CORE_ALIVE,
  input  wire logic            NV_DONE,
  input  wire logic            CRC_DONE,
  input  wire logic            CRC_OK,
  input  wire logic [15:0]     SUPPLY_FAULT,
  input  wire logic            PG_IN,
  input  wire logic            FAULT_IN,
  input  wire logic            MONITOR_DISABLE_N,
  output logic                 FAULT_OUT,
  output logic                 FAULT_OE,
  output logic                 CMD_READY,
  output logic                 CMD_EXEC,
  output logic [7:0]           PAGE_RD,
  output pss_pkg::route_t      ROUTE,
  output pss_pkg::status_t     STATUS,
  output logic [7:0]           VENDOR_STATUS,
  output logic                 ALERT,
  output logic                 NV_LOAD,
  output logic                 CRC_RUN,
  output logic                 PINS_HIZ,
  output logic                 MONITOR_ON,
  output logic                 PG_OUT,
  output logic                 GLOBAL_OFF,
  output logic                 ADDR_SELECT_BIT0
);
  import pss_pkg::*;

  typedef struct packed {
    phase_t           phase;
    logic             fin1;
    logic             fin2;
    logic             mon1;
    logic             mon2;
    logic             addr0;
    logic [7:0]       page;
    route_t           route;
    logic [CNT_W-1:0] tick_cnt;
    logic [CNT_W-1:0] wd_cnt;
    logic             alive;
    logic             wd_flag;
    logic             vsum;
    logic             comm_fault_bit;
    logic             alert;
    logic             pg_out;
    logic             drive;
    logic             global_off;
    logic             exec;
  } state_t;

  localparam logic [CNT_W-1:0] TICK_LAST = CNT_W'(REFRESH_CYCLES - 1);
  localparam logic [CNT_W-1:0] WDT_LAST  = CNT_W'(WDT_CYCLES - 1);

  function automatic page_kind_t kind_of(input logic [7:0] p);
    if (p <= PAGE_SUP_LAST) begin
      return K_SUP;
    end else if (p >= PAGE_TEMP_INT && p <= PAGE_TEMP_END) begin
      return K_TEMP;
    end else if (p == PAGE_ALL) begin
      return K_ALL;
    end
    return K_RSVD;
  endfunction

  function automatic route_t route_of(input logic [7:0] p);
    route_t     r;
    logic [7:0] d;
    logic [7:0] e;
    r = '0;
    d = p - PAGE_TEMP_INT;
    e = d - 8'h01;
    unique case (kind_of(p))
      K_SUP: begin
        r.supply_sel  = 16'h0001 << p[3:0];
        r.margin_addr = DAC_BASE + {p[3:2], 6'h00};
        r.margin_out  = p[1:0];
      end
      K_TEMP: begin
        r.temp_sel = 5'h01 << d[2:0];
        if (d != 8'h00) begin
          r.remote_addr = TEMP_BASE + {e[6:0], 1'b0};
        end
      end
      K_ALL: begin
        r.supply_sel = 16'hffff;
        r.temp_sel   = 5'h1f;
        r.all_pages  = 1'b1;
      end
      K_RSVD: begin
        r = '0;
      end
    endcase
    return r;
  endfunction

  logic [1:0] rst_sync;
  logic       rst_n;
  state_t     st;
  state_t     next_st;
  logic       run;
  logic       wd_fire;
  logic       any_fault;
  logic       mon_off;
  logic       bad_cmd;
  logic       clear_cmd;

  // reset enters asynchronously but is released on the clock
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  always_comb begin
    run       = st.phase == PH_RUN;
    wd_fire   = run && st.wd_cnt == WDT_LAST;
    any_fault = (|SUPPLY_FAULT) || st.drive;
    mon_off   = run && !st.mon2 && !any_fault && st.pg_out;
    clear_cmd = run && CMD.valid && CMD.write && CMD.code == CMD_CLEAR;
    // common commands carry neither class flag and never depend on the page
    bad_cmd   = run && CMD.valid && CMD.code != CMD_PAGE
                && (CMD.supply_only || CMD.temp_only)
                && (kind_of(st.page) == K_RSVD
                    || (CMD.supply_only && kind_of(st.page) == K_TEMP)
                    || (CMD.temp_only && kind_of(st.page) == K_SUP));
  end

  always_comb begin
    next_st      = st;
    next_st.fin1 = FAULT_IN;
    next_st.fin2 = st.fin1;
    next_st.mon1 = MONITOR_DISABLE_N;
    next_st.mon2 = st.mon1;
    next_st.exec = 1'b0;
    next_st.tick_cnt = (st.tick_cnt == TICK_LAST) ? '0 : st.tick_cnt + 1'b1;
    // the core must prove itself alive within each refresh window
    next_st.alive = st.alive || CORE_ALIVE;
    if (st.tick_cnt == TICK_LAST) begin
      next_st.alive = CORE_ALIVE;
    end
    if (run) begin
      next_st.wd_cnt = st.wd_cnt + 1'b1;
      if (st.tick_cnt == TICK_LAST && st.alive) begin
        next_st.wd_cnt = '0;
      end
    end else begin
      next_st.wd_cnt = '0;
    end
    // clear first so an event in the same cycle wins
    if (clear_cmd) begin
      next_st.vsum    = 1'b0;
      next_st.wd_flag = 1'b0;
      next_st.comm_fault_bit     = 1'b0;
      next_st.alert   = 1'b0;
    end
    if (bad_cmd || (run && DATA_FAULT)) begin
      next_st.comm_fault_bit   = 1'b1;
      next_st.alert = 1'b1;
    end
    if (run && CMD.valid && !bad_cmd) begin
      next_st.exec = 1'b1;
      if (CMD.write && CMD.code == CMD_PAGE) begin
        next_st.page  = CMD.data;
        next_st.route = route_of(CMD.data);
      end
    end
    unique case (st.phase)
      PH_LOAD: begin
        next_st.drive = 1'b1;
        if (NV_DONE) begin
          next_st.phase = PH_CHECK;
        end
      end
      PH_CHECK: begin
        next_st.drive = 1'b1;
        if (CRC_DONE) begin
          next_st.phase = CRC_OK ? PH_RUN : PH_NULL;
          // strap is long settled by now; the host keeps it undriven
          next_st.addr0 = st.mon2;
        end
      end
      PH_NULL: begin
        next_st.drive = 1'b1;
      end
      PH_RUN: begin
        if (!mon_off) begin
          next_st.pg_out = PG_IN;
          next_st.drive  = |(SUPPLY_FAULT & CFG.global_mask);
        end
        next_st.global_off = !CFG.fault_ignore && !st.fin2 && !st.drive;
      end
      default: begin
        next_st.phase = PH_LOAD;
      end
    endcase
    if (!run) begin
      next_st.global_off = 1'b0;
    end
    if (wd_fire) begin
      // self reset: selection restarts, the event itself is remembered
      next_st.phase   = PH_LOAD;
      next_st.page    = PAGE_RESET;
      next_st.route   = route_of(PAGE_RESET);
      next_st.pg_out  = 1'b0;
      next_st.drive   = 1'b1;
      next_st.vsum    = 1'b1;
      next_st.wd_flag = 1'b1;
      if (CFG.alert_en) begin
        next_st.alert = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      st          <= '0;
      st.phase    <= PH_LOAD;
      st.page     <= PAGE_RESET;
      st.route    <= '{supply_sel: 16'h0001, margin_addr: DAC_BASE, default: '0};
      st.drive    <= 1'b1;
      st.fin1     <= 1'b1;
      st.fin2     <= 1'b1;
      st.mon1     <= 1'b1;
      st.mon2     <= 1'b1;
      st.addr0    <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // the pad only ever pulls low; the pad ring resolves the wire
  assign FAULT_OUT     = 1'b0;
  assign FAULT_OE      = st.drive;
  assign CMD_READY     = run;
  assign CMD_EXEC      = st.exec;
  assign PAGE_RD       = st.page;
  assign ROUTE         = st.route;
  assign STATUS        = '{vendor_summary: st.vsum, comm_fault: st.comm_fault_bit,
                           watchdog: st.wd_flag, fault_level: st.fin2};
  always_comb begin
    VENDOR_STATUS = 8'h00;
    if (st.page == PAGE_ALL) begin
      VENDOR_STATUS[VST_WDOG]     = st.wd_flag;
      VENDOR_STATUS[VST_FAULT_IN] = st.fin2;
    end
  end
  assign ALERT            = st.alert;
  assign NV_LOAD          = st.phase == PH_LOAD;
  assign CRC_RUN          = st.phase == PH_CHECK;
  assign PINS_HIZ         = st.phase == PH_NULL;
  assign MONITOR_ON       = run && !mon_off;
  assign PG_OUT           = st.pg_out;
  assign GLOBAL_OFF       = st.global_off;
  assign ADDR_SELECT_BIT0 = st.addr0;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n);

  a_wdt_expire: assert property (wd_fire |=> NV_LOAD && !CMD_READY) else $error("no self reset");
  a_wdt_refresh: assert property (run && st.tick_cnt == TICK_LAST && st.alive |=> st.wd_cnt == '0)
    else $error("refresh lost");
  a_reload_then_check: assert property (NV_LOAD && NV_DONE |=> CRC_RUN) else $error("no reload");
  a_wdt_status: assert property (wd_fire |=> STATUS.vendor_summary && STATUS.watchdog)
    else $error("watchdog bits");
  a_wdt_alert: assert property (wd_fire && CFG.alert_en |=> ALERT) else $error("watchdog alert");
  a_crc_null: assert property (CRC_RUN && CRC_DONE && !CRC_OK |=> (PINS_HIZ && FAULT_OE) [*2])
    else $error("null state");
  a_fault_open_drain: assert property (FAULT_OUT == 1'b0) else $error("line driven high");
  a_global_drive: assert property (run && !mon_off && |(SUPPLY_FAULT & CFG.global_mask) |=> FAULT_OE)
    else $error("global fault");
  a_ext_shutdown: assert property (run && !CFG.fault_ignore && !st.fin2 && !st.drive |=> GLOBAL_OFF)
    else $error("no shutdown");
  a_fault_report: assert property (PAGE_RD == PAGE_ALL |-> VENDOR_STATUS[VST_FAULT_IN] == $past(FAULT_IN, 2))
    else $error("line level");
  a_fault_held: assert property (!CMD_READY |-> FAULT_OE) else $error("line released early");
  a_mon_freeze: assert property (mon_off && !wd_fire |=> PG_OUT == $past(PG_OUT) && FAULT_OE == $past(FAULT_OE))
    else $error("freeze broken");
  a_mon_ignore: assert property (run && (|SUPPLY_FAULT || !PG_OUT) |-> MONITOR_ON) else $error("disable honoured");
  a_page_write: assert property (CMD_READY && CMD.valid && CMD.write && CMD.code == CMD_PAGE && !wd_fire
    |=> PAGE_RD == $past(CMD.data)) else $error("page lost");
  a_comm_fault: assert property (bad_cmd |=> STATUS.comm_fault && ALERT && !CMD_EXEC)
    else $error("comm fault");
  a_all_pages: assert property (PAGE_RD == PAGE_ALL |-> ROUTE.all_pages && ROUTE.supply_sel == 16'hffff)
    else $error("all pages");
  a_supply_map: assert property (PAGE_RD <= PAGE_SUP_LAST |-> ROUTE.supply_sel == (16'h0001 << PAGE_RD[3:0])
    && ROUTE.margin_out == PAGE_RD[1:0]) else $error("supply map");
endmodule
`default_nettype wire

// File: test/pss_peer.sv
// far-side model: core answers, liveness pulses, shared fault wire, monitor switch
`default_nettype none
module pss_peer (
  input  wire logic clk,
  input  wire logic nv_load,
  input  wire logic crc_run,
  input  wire logic crc_good,
  input  wire logic alive_en,
  input  wire logic fault_oe,
  input  wire logic peer_pull,
  input  wire logic mon_pull,
  output logic      nv_done,
  output logic      crc_done,
  output logic      crc_ok,
  output logic      core_alive,
  output logic      fault_wire,
  output logic      monitor_disable_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] tick = 2'h0;
  always_ff @(posedge clk) begin
    nv_done  <= nv_load;
    crc_done <= crc_run;
    tick     <= tick + 2'h1;
  end
  assign crc_ok     = crc_good;
  // pulse every 4 cycles, well inside the shortened refresh window
  assign core_alive = alive_en && (tick == 2'h0);
  // pull-up: a released line reads high
  assign fault_wire = ~(fault_oe | peer_pull);
  // switch open during reset so the strap reads high; no sequencing is issued while closed
  assign monitor_disable_n = ~mon_pull;
endmodule
`default_nettype wire

// File: test/page_select_supervisor_tb.sv
// self-checking bench for the page select supervisor
`default_nettype none
module page_select_supervisor_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pss_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, data_fault = 1'b0, pg_in = 1'b0, crc_good = 1'b1;
  logic alive_en = 1'b1, peer_pull = 1'b0, mon_pull = 1'b0;
  cmd_t cmd = '0;
  cfg_t cfg = '0;
  logic [15:0] sfault = 16'h0000;
  logic nv_done, crc_done, crc_ok, core_alive, fault_wire, mon_n, fault_out, fault_oe, rdy, exec;
  logic alert, nv_load, crc_run, hiz, mon_on, pg_out, goff, strap;
  logic [7:0] page_rd, vstat;
  route_t route;
  status_t st;
  int bad_count = 0, checks_done = 0, cyc = 0, seed = 98;

  page_select_supervisor #(.REFRESH_CYCLES(8), .WDT_CYCLES(40)) dut_u (
    .CLK(clk), .RST_B(rst_b), .CMD(cmd), .DATA_FAULT(data_fault), .CFG(cfg),
    .CORE_ALIVE(core_alive), .NV_DONE(nv_done), .CRC_DONE(crc_done), .CRC_OK(crc_ok),
    .SUPPLY_FAULT(sfault), .PG_IN(pg_in), .FAULT_IN(fault_wire), .MONITOR_DISABLE_N(mon_n),
    .FAULT_OUT(fault_out), .FAULT_OE(fault_oe), .CMD_READY(rdy), .CMD_EXEC(exec),
    .PAGE_RD(page_rd), .ROUTE(route), .STATUS(st), .VENDOR_STATUS(vstat), .ALERT(alert),
    .NV_LOAD(nv_load), .CRC_RUN(crc_run), .PINS_HIZ(hiz), .MONITOR_ON(mon_on),
    .PG_OUT(pg_out), .GLOBAL_OFF(goff), .ADDR_SELECT_BIT0(strap));

  pss_peer peer_u (
    .clk(clk), .nv_load(nv_load), .crc_run(crc_run), .crc_good(crc_good), .alive_en(alive_en),
    .fault_oe(fault_oe), .peer_pull(peer_pull), .mon_pull(mon_pull), .nv_done(nv_done),
    .crc_done(crc_done), .crc_ok(crc_ok), .core_alive(core_alive), .fault_wire(fault_wire),
    .monitor_disable_n(mon_n));

  always #20 clk = ~clk;

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ceiling sits far above the several hundred cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count = bad_count + 1;
      close_out();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] dac_addr(input logic [7:0] p);
    return DAC_BASE + 8'h40 * p[3:2];
  endfunction

  task automatic send(input logic so, input logic to, input logic [7:0] code, input logic [7:0] data);
    @(negedge clk);
    cmd = '{1'b1, 1'b1, so, to, code, data};
    @(negedge clk);
    cmd = '0;
  endtask

  task automatic page(input logic [7:0] p);
    send(1'b0, 1'b0, CMD_PAGE, p);
    chk({exec, page_rd}, {1'b1, p});
    if (p <= PAGE_SUP_LAST) begin
      chk(route.supply_sel, 16'h0001 << p);
      chk({route.margin_addr, route.margin_out}, {dac_addr(p), p[1:0]});
    end
    if (p >= PAGE_TEMP_INT && p <= PAGE_TEMP_END) chk(route.temp_sel, 5'h01 << (p - PAGE_TEMP_INT));
    if (p > PAGE_TEMP_INT && p <= PAGE_TEMP_END) chk(route.remote_addr, TEMP_BASE + 8'h02 * (p - 8'h12));
    chk(route.all_pages, p == PAGE_ALL);
  endtask

  task automatic boot(input logic good);
    crc_good = good;
    rst_b = 1'b0;
    repeat (5) @(negedge clk);
    chk({fault_oe, page_rd}, {1'b1, PAGE_RESET});
    rst_b = 1'b1;
    repeat (60) begin
      @(negedge clk);
      if (rdy === 1'b1) break;
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  initial begin
    int n;
    cfg.alert_en = 1'b1;
    boot(1'b1);
    // the line is let go on the first edge of the run phase
    wait_cyc(1);
    chk({rdy, fault_oe, strap}, 3'b101);
    $display("test boot done");
    for (int i = 0; i < 22; i++) page(8'(i));
    page(PAGE_ALL);
    repeat (8) page(8'($unsigned($random(seed)) % 22));
    $display("test pages done");
    page(8'h12);
    send(1'b1, 1'b0, 8'h20, 8'h00);
    chk({exec, st.comm_fault, alert}, 3'b011);
    send(1'b0, 1'b0, CMD_CLEAR, 8'h00);
    chk({st.comm_fault, alert}, 2'b00);
    send(1'b0, 1'b1, 8'h20, 8'h00);
    chk({exec, st.comm_fault}, 2'b10);
    page(8'h10);
    send(1'b1, 1'b0, 8'h20, 8'h00);
    chk({exec, st.comm_fault}, 2'b01);
    send(1'b0, 1'b0, 8'h01, 8'h80);
    chk(exec, 1'b1);
    page(PAGE_ALL);
    send(1'b0, 1'b0, CMD_CLEAR, 8'h00);
    send(1'b1, 1'b0, 8'h01, 8'h80);
    chk({exec, st.comm_fault}, 2'b10);
    send(1'b0, 1'b1, 8'h20, 8'h00);
    chk({exec, st.comm_fault}, 2'b10);
    data_fault = 1'b1;
    wait_cyc(1);
    data_fault = 1'b0;
    wait_cyc(1);
    chk({st.comm_fault, alert}, 2'b11);
    $display("test commands done");
    repeat (6) begin
      cfg.global_mask = 16'($random(seed));
      sfault = 16'($random(seed));
      wait_cyc(3);
      chk(fault_oe, |(sfault & cfg.global_mask));
      chk(fault_wire, !fault_oe);
    end
    sfault = 16'h0000;
    for (int i = 0; i < 2; i++) begin
      cfg.fault_ignore = i[0];
      peer_pull = 1'b1;
      wait_cyc(5);
      chk({goff, vstat[VST_FAULT_IN]}, {~i[0], 1'b0});
      peer_pull = 1'b0;
      wait_cyc(5);
      chk({goff, vstat[VST_FAULT_IN]}, 2'b01);
    end
    $display("test fault line done");
    for (int i = 0; i < 3; i++) begin
      pg_in = (i != 1);
      sfault = (i == 2) ? 16'h0001 : 16'h0000;
      wait_cyc(4);
      chk(pg_out, i != 1);
      mon_pull = 1'b1;
      wait_cyc(5);
      chk(mon_on, i != 0);
      mon_pull = 1'b0;
      wait_cyc(5);
      chk(mon_on, 1'b1);
    end
    sfault = 16'h0000;
    $display("test monitor disable done");
    for (int a = 1; a >= 0; a--) begin
      cfg.alert_en = a[0];
      send(1'b0, 1'b0, CMD_CLEAR, 8'h00);
      page(8'h05);
      wait_cyc(100);
      chk(nv_load, 1'b0);
      alive_en = 1'b0;
      n = 0;
      while (nv_load !== 1'b1 && n < 80) begin
        wait_cyc(1);
        n++;
      end
      chk(n >= 28 && n <= 52, 1'b1);
      alive_en = 1'b1;
      repeat (60) begin
        wait_cyc(1);
        if (rdy === 1'b1) break;
      end
      chk({rdy, page_rd}, {1'b1, PAGE_RESET});
      chk({st.vendor_summary, st.watchdog, alert}, {2'b11, a[0]});
      page(PAGE_ALL);
      chk(vstat[VST_WDOG], 1'b1);
    end
    $display("test watchdog done");
    boot(1'b0);
    chk({hiz, fault_oe, rdy}, 3'b110);
    $display("test integrity failure done");
    close_out();
  end
endmodule
`default_nettype wire
